// file: sfsm_consts.vh
`ifndef SFSM_CONSTS_VH
`define SFSM_CONSTS_VH
// ************************************************************
// Register map
// ************************************************************
`define SFSM_A_CTRL 8'h00
`define SFSM_A_FAULT 8'h04
`define SFSM_A_TINT 8'h08
`define SFSM_A_TINFO 8'h0C
`define SFSM_A_STATE 8'h10
`define SFSM_A_CHEN 8'h14
`define SFSM_A_SUVIEN 8'h18
`define SFSM_A_FUVIEN 8'h1C
`define SFSM_A_AMASK 8'h20
`define SFSM_A_LEVEL 8'h40
`define SFSM_CTRL_RST 9'h0B0
// Control bits
`define SFSM_C_PECEN 0
`define SFSM_C_PECREQ 1
`define SFSM_C_FIRQ 2
`define SFSM_C_FSYNC 3
`define SFSM_C_THEN 4
`define SFSM_C_SECEN 5
`define SFSM_C_TIEN 6
`define SFSM_C_PWR 7
`define SFSM_C_REC 8
// Fault bits
`define SFSM_F_THERM 0
`define SFSM_F_SEC 1
`define SFSM_F_DED 2
`define SFSM_F_CLK 3
`define SFSM_F_STATE 4
`define SFSM_F_CRC 5
`define SFSM_F_WRBK 6
`define SFSM_F_PEC 7
`define SFSM_F_IRQSH 8
`define SFSM_F_SYNSH 9
// ************************************************************
// Timing
// ************************************************************
`define SFSM_CLK_NS 4
`define SFSM_REF_NS 48
`define SFSM_REF_NOM (`SFSM_REF_NS / `SFSM_CLK_NS)
`define SFSM_REF_MIN (`SFSM_REF_NOM * 3 / 4)
`define SFSM_REF_MAX ((`SFSM_REF_NOM * 5 + 3) / 4)
`define SFSM_SHORT_SETTLE 4'h4
`define SFSM_CRC_POLY 8'h07
`endif

// file: sfsm_host_model.sv
`timescale 1ns/1ps
module sfsm_host_model (
    // Open-drain pins seen by the host
    input wire irq_oe,
    input wire irq_out,
    input wire sync_oe,
    input wire sync_out,
    input wire irq_short,
    input wire sync_short,
    output wire irq_pin,
    output wire sync_pin,
    // Reference clock source
    input wire ref_run,
    output reg ref_clk
);
    // ************************************************************
    // Pins with pull-ups; a short to power beats the pull-down
    // ************************************************************
    assign irq_pin = irq_short | !(irq_oe && !irq_out);
    assign sync_pin = sync_short | !(sync_oe && !sync_out);
    initial ref_clk = 1'b0;
    always #24 if (ref_run) ref_clk = !ref_clk;
endmodule

// file: sfsm_monitor.v
// The implementer's own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`include "sfsm_consts.vh"
module sfsm_monitor #(
    parameter NCH = 6,
    parameter LVLW = 10,
    parameter CFG_AW = 4
) (
    // Clock, reset, enable
    input wire sys_clk,
    input wire rst_b,
    input wire clk_en,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [3:0] wb_sel_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Asynchronous pins and sensors
    input wire shutdown_control_pin,
    input wire sleep_control_pin,
    input wire ref_clk,
    input wire temp_hot,
    // Interrupt pin, open drain
    input wire fault_irq_n_in,
    output reg fault_irq_n_out,
    output reg fault_irq_n_oe,
    // Sync pin, open drain
    input wire sync_pin_in,
    output reg sync_pin_out,
    output reg sync_pin_oe,
    // Start-up loader and self-test results
    input wire boot_done,
    input wire nvm_single_err,
    input wire nvm_double_err,
    input wire selftest_done,
    input wire logic_selftest_fail,
    input wire analog_selftest_fail,
    // Serial write path with check code
    input wire host_wr_valid,
    input wire [CFG_AW-1:0] host_wr_addr,
    input wire [7:0] host_wr_data,
    input wire host_wr_code_present,
    input wire [7:0] host_wr_code,
    // Converter readings
    input wire adc_valid,
    input wire [2:0] adc_chan,
    input wire [LVLW-1:0] adc_data,
    // Comparator enables per channel and converter run
    output reg [NCH-1:0] fast_ov_en,
    output reg [NCH-1:0] slow_ov_en,
    output reg [NCH-1:0] fast_uv_en,
    output reg [NCH-1:0] slow_uv_en,
    output reg adc_run
);
    localparam ST_BOOT = 5'h01;
    localparam ST_IDLE = 5'h02;
    localparam ST_ACT = 5'h04;
    localparam ST_SLEEP = 5'h08;
    localparam ST_FAIL = 5'h10;
    localparam CFG_N = 1 << CFG_AW;
    localparam [7:0] REF_MIN = `SFSM_REF_MIN;
    localparam [7:0] REF_MAX = `SFSM_REF_MAX;
    function [7:0] crc8;
        input [7:0] acc;
        input [7:0] din;
        integer k;
        reg [7:0] c;
        begin
            c = acc ^ din;
            for (k = 0; k < 8; k = k + 1)
                c = c[7] ? ((c << 1) ^ `SFSM_CRC_POLY) : (c << 1);
            crc8 = c;
        end
    endfunction

    // ********************************************************
    // Pin synchronisers
    // ********************************************************
    reg [5:0] sync_a;
    reg [5:0] sync_b;
    reg [5:0] sync_c;
    wire [5:0] pins_raw = {sync_pin_in, fault_irq_n_in, temp_hot,
                           ref_clk, sleep_control_pin, shutdown_control_pin};
    wire shdn_rise = sync_b[0] & ~sync_c[0];
    wire shdn_fall = ~sync_b[0] & sync_c[0];
    wire slp_rise = sync_b[1] & ~sync_c[1];
    wire slp_fall = ~sync_b[1] & sync_c[1];
    wire ref_rise = sync_b[2] & ~sync_c[2];
    wire hot = sync_b[3];
    wire hot_rise = sync_b[3] & ~sync_c[3];
    wire irq_pin_hi = sync_b[4];
    wire sync_pin_hi = sync_b[5];
    always @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            sync_a <= 6'h00;
            sync_b <= 6'h00;
            sync_c <= 6'h00;
        end
        else if (clk_en)
        begin
            sync_a <= pins_raw;
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    // ********************************************************
    // Registers and bus decode
    // ********************************************************
    reg [8:0] ctrl;
    reg [9:0] fault;
    reg [1:0] tint;
    reg [4:0] tinfo;
    reg done_status;
    reg [4:0] state;
    reg [NCH-1:0] ch_en;
    reg [NCH-1:0] suv_ien;
    reg [NCH-1:0] fuv_ien;
    reg [NCH-1:0] amask;
    reg [LVLW*NCH-1:0] level;
    wire high_power_mode = ctrl[`SFSM_C_PWR];
    wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr = bus_req & wb_we_i;
    wire wr0 = wr & wb_sel_i[0];
    wire wr1 = wr & wb_sel_i[1];
    wire w_ctrl = wb_adr_i == `SFSM_A_CTRL;
    wire w_fault = wb_adr_i == `SFSM_A_FAULT;
    wire w_tint = wb_adr_i == `SFSM_A_TINT;
    wire record_start_bit = wr1 & w_ctrl & wb_dat_i[`SFSM_C_REC];
    wire [9:0] fclr = {wr1 ? wb_dat_i[9:8] : 2'h0, wr0 ? wb_dat_i[7:0] : 8'h00}
                      & {10{w_fault}};
    wire pwr_ok = state == ST_IDLE || state == ST_FAIL || state == ST_SLEEP;
    // A low-power request outside idle, fail or sleep is dropped silently
    wire pwr_bit = pwr_ok ? wb_dat_i[`SFSM_C_PWR] : ctrl[`SFSM_C_PWR];

    reg [31:0] rdata;
    integer i;
    always @*
    begin
        rdata = 32'h00000000;
        case (wb_adr_i)
            `SFSM_A_CTRL: rdata[7:0] = ctrl[7:0];
            `SFSM_A_FAULT: rdata[9:0] = fault;
            `SFSM_A_TINT: rdata[1:0] = tint;
            `SFSM_A_TINFO: rdata[4:0] = tinfo;
            `SFSM_A_STATE: rdata[8:0] = {done_status, 3'h0, state};
            `SFSM_A_CHEN: rdata[NCH-1:0] = ch_en;
            `SFSM_A_SUVIEN: rdata[NCH-1:0] = suv_ien;
            `SFSM_A_FUVIEN: rdata[NCH-1:0] = fuv_ien;
            `SFSM_A_AMASK: rdata[NCH-1:0] = amask;
            default:
                for (i = 0; i < NCH; i = i + 1)
                    if (wb_adr_i == `SFSM_A_LEVEL + 4 * i)
                        rdata[LVLW-1:0] = level[i*LVLW +: LVLW];
        endcase
    end

    always @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            ctrl <= `SFSM_CTRL_RST;
            ch_en <= {NCH{1'b0}};
            suv_ien <= {NCH{1'b0}};
            fuv_ien <= {NCH{1'b0}};
            amask <= {NCH{1'b0}};
        end
        else if (clk_en)
        begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? rdata : 32'h00000000;
            if (wr0 && w_ctrl)
                ctrl[7:0] <= {pwr_bit, wb_dat_i[6:0]};
            if (wr0 && wb_adr_i == `SFSM_A_CHEN)
                ch_en <= wb_dat_i[NCH-1:0];
            if (wr0 && wb_adr_i == `SFSM_A_SUVIEN)
                suv_ien <= wb_dat_i[NCH-1:0];
            if (wr0 && wb_adr_i == `SFSM_A_FUVIEN)
                fuv_ien <= wb_dat_i[NCH-1:0];
            if (wr0 && wb_adr_i == `SFSM_A_AMASK)
                amask <= wb_dat_i[NCH-1:0];
        end
    end

    // ********************************************************
    // Operating state
    // ********************************************************
    reg [4:0] next_state;
    // Triggers only count in high-power mode
    wire go_act = high_power_mode & (shdn_rise | record_start_bit);
    always @*
    begin
        next_state = state;
        case (state)
            ST_BOOT:
                if (boot_done)
                    next_state = (tinfo[1] | tinfo[2] | tinfo[3] |
                        nvm_double_err) ? ST_FAIL : ST_IDLE;
            ST_IDLE, ST_FAIL:
                if (go_act)
                    next_state = ST_ACT;
            ST_ACT:
                if (high_power_mode & shdn_fall)
                    next_state = ST_IDLE;
                else if (high_power_mode & slp_fall)
                    next_state = ST_SLEEP;
            ST_SLEEP:
                if (high_power_mode & shdn_fall)
                    next_state = ST_IDLE;
                else if (high_power_mode & (slp_rise | record_start_bit))
                    next_state = ST_ACT;
            default:
                next_state = ST_FAIL;
        endcase
    end
    wire [4:0] st_m1 = state - 5'h01;
    wire st_bad = (state == 5'h00) | ((state & st_m1) != 5'h00);
    // ********************************************************
    // Clock cross-check
    // ********************************************************
    reg [7:0] ref_cnt;
    reg ref_armed;
    wire ref_bad = ref_rise ? (ref_armed &&
        (ref_cnt < REF_MIN || ref_cnt > REF_MAX)) : (ref_cnt > REF_MAX);
    // ********************************************************
    // Host writes, readback and runtime CRC
    // ********************************************************
    reg [7:0] cfg [0:CFG_N-1];
    reg rb_pend;
    reg [CFG_AW-1:0] rb_addr;
    reg [7:0] rb_data;
    reg [CFG_AW-1:0] scan_idx;
    reg [7:0] scan_acc;
    reg [7:0] golden;
    reg dirty;
    wire [7:0] pec_calc = crc8(crc8(8'h00, {{(8-CFG_AW){1'b0}},
                               host_wr_addr}), host_wr_data);
    wire pec_need = ctrl[`SFSM_C_PECEN] &
                    (ctrl[`SFSM_C_PECREQ] | host_wr_code_present);
    wire pec_bad = pec_need & (~host_wr_code_present |
                   (host_wr_code != pec_calc));
    wire wr_take = host_wr_valid & ~pec_bad;
    wire [7:0] scan_next = crc8(scan_acc, cfg[scan_idx]);
    wire scan_last = scan_idx == CFG_N - 1;
    wire busy = host_wr_valid | rb_pend;
    // ********************************************************
    // Pin drive and short detection
    // ********************************************************
    reg [3:0] irq_low_cnt;
    reg [3:0] sync_low_cnt;
    // Short flags cannot pull the pin: a shorted pin would hide them anyway
    wire irq_want = (fault[7:0] != 8'h00) | tint[0] | tint[1] |
                    ctrl[`SFSM_C_FIRQ];
    wire irq_short = fault_irq_n_oe &&
        irq_low_cnt == `SFSM_SHORT_SETTLE && irq_pin_hi;
    wire sync_short = sync_pin_oe &&
        sync_low_cnt == `SFSM_SHORT_SETTLE && sync_pin_hi;
    wire therm_set = ctrl[`SFSM_C_THEN] & (high_power_mode ? hot : hot_rise);
    wire [9:0] fset;
    assign fset[`SFSM_F_THERM] = therm_set;
    assign fset[`SFSM_F_SEC] = nvm_single_err & ctrl[`SFSM_C_SECEN];
    assign fset[`SFSM_F_DED] = nvm_double_err;
    assign fset[`SFSM_F_CLK] = ref_bad;
    assign fset[`SFSM_F_STATE] = st_bad;
    assign fset[`SFSM_F_CRC] = ~busy & scan_last & ~dirty &
                               (scan_next != golden);
    assign fset[`SFSM_F_WRBK] = rb_pend & (cfg[rb_addr] != rb_data);
    assign fset[`SFSM_F_PEC] = host_wr_valid & pec_bad;
    assign fset[`SFSM_F_IRQSH] = irq_short;
    assign fset[`SFSM_F_SYNSH] = sync_short;
    // Double error and clock failure ignore the clear; thermal waits for cool
    wire [9:0] fclr_ok = fclr & ~10'h00C &
        {9'h1FF, ~hot};
    always @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            state <= ST_BOOT;
            fault <= 10'h000;
            tint <= 2'h0;
            tinfo <= 5'h00;
            done_status <= 1'b0;
            ref_cnt <= 8'h00;
            ref_armed <= 1'b0;
            rb_pend <= 1'b0;
            rb_addr <= {CFG_AW{1'b0}};
            rb_data <= 8'h00;
            scan_idx <= {CFG_AW{1'b0}};
            scan_acc <= 8'h00;
            golden <= 8'h00;
            dirty <= 1'b1;
            irq_low_cnt <= 4'h0;
            sync_low_cnt <= 4'h0;
            fault_irq_n_out <= 1'b0;
            fault_irq_n_oe <= 1'b0;
            sync_pin_out <= 1'b0;
            sync_pin_oe <= 1'b0;
            level <= {LVLW*NCH{1'b0}};
            fast_ov_en <= {NCH{1'b0}};
            slow_ov_en <= {NCH{1'b0}};
            fast_uv_en <= {NCH{1'b0}};
            slow_uv_en <= {NCH{1'b0}};
            adc_run <= 1'b0;
            for (i = 0; i < CFG_N; i = i + 1)
                cfg[i] <= 8'h00;
        end
        else if (clk_en)
        begin
            state <= next_state;
            // Hardware set beats a software clear in the same cycle
            fault <= (fault & ~fclr_ok) | fset;
            if (selftest_done)
            begin
                done_status <= 1'b1;
                tinfo[4] <= 1'b1;
                tinfo[3] <= tinfo[3] | analog_selftest_fail;
                tinfo[2] <= tinfo[2] | logic_selftest_fail;
            end
            if (nvm_single_err)
                tinfo[0] <= 1'b1;
            if (nvm_double_err)
                tinfo[1] <= 1'b1;
            tint[0] <= tint[0] | (selftest_done & logic_selftest_fail);
            tint[1] <= (tint[1] & ~(wr0 & w_tint & wb_dat_i[1])) |
                (selftest_done & ctrl[`SFSM_C_TIEN]);
            // Clock check ignores a too-short first partial reference period
            if (ref_rise)
            begin
                ref_cnt <= 8'h00;
                ref_armed <= 1'b1;
            end
            else if (ref_cnt <= REF_MAX)
                ref_cnt <= ref_cnt + 8'h01;
            if (wr_take)
                cfg[host_wr_addr] <= host_wr_data;
            rb_pend <= wr_take;
            rb_addr <= host_wr_addr;
            rb_data <= host_wr_data;
            if (host_wr_valid)
            begin
                dirty <= dirty | wr_take;
                scan_idx <= {CFG_AW{1'b0}};
                scan_acc <= 8'h00;
            end
            else if (!busy)
            begin
                scan_idx <= scan_idx + {{(CFG_AW-1){1'b0}}, 1'b1};
                scan_acc <= scan_last ? 8'h00 : scan_next;
                if (scan_last && dirty)
                begin
                    golden <= scan_next;
                    dirty <= 1'b0;
                end
            end
            fault_irq_n_oe <= irq_want;
            sync_pin_oe <= ctrl[`SFSM_C_FSYNC];
            irq_low_cnt <= fault_irq_n_oe ? irq_low_cnt +
                {3'h0, irq_low_cnt != `SFSM_SHORT_SETTLE} : 4'h0;
            sync_low_cnt <= sync_pin_oe ? sync_low_cnt +
                {3'h0, sync_low_cnt != `SFSM_SHORT_SETTLE} : 4'h0;
            if (adc_valid && adc_run && adc_chan < NCH)
                level[adc_chan*LVLW +: LVLW] <= adc_data;
            adc_run <= high_power_mode & (state != ST_BOOT);
            fast_ov_en <= ch_en;
            slow_ov_en <= high_power_mode ? ch_en : {NCH{1'b0}};
            fast_uv_en <= {NCH{1'b0}};
            slow_uv_en <= {NCH{1'b0}};
            case (state)
                ST_ACT:
                begin
                    slow_ov_en <= ch_en;
                    fast_uv_en <= ch_en & fuv_ien;
                    slow_uv_en <= ch_en & suv_ien;
                end
                ST_SLEEP:
                begin
                    fast_uv_en <= ch_en & fuv_ien & ~amask;
                    slow_uv_en <= ch_en & suv_ien & ~amask & {NCH{high_power_mode}};
                end
                ST_IDLE, ST_FAIL:
                    fast_ov_en <= ch_en;
                default:
                begin
                    fast_ov_en <= {NCH{1'b0}};
                    slow_ov_en <= {NCH{1'b0}};
                end
            endcase
        end
    end
endmodule

// file: sfsm_monitor_assertions.sv
`timescale 1ns/1ps
`include "sfsm_consts.vh"
module sfsm_mon_chk #(
    parameter NCH = 6
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst_b,
    input wire clk_en,
    // Bus
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [3:0] wb_sel_i,
    input wire wb_ack_o,
    // Pins and enables
    input wire ref_clk,
    input wire boot_done,
    input wire fault_irq_n_oe,
    input wire sync_pin_oe,
    input wire [NCH-1:0] fast_ov_en,
    input wire [NCH-1:0] slow_ov_en,
    input wire [NCH-1:0] fast_uv_en,
    input wire [NCH-1:0] slow_uv_en,
    input wire adc_run
);
    // ************************************************************
    // Helpers
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    reg [5:0] still_cnt;
    reg ref_q;
    reg booted;
    reg stalled;
    wire wr_ctrl = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && clk_en
        && wb_adr_i == `SFSM_A_CTRL && wb_sel_i[0];
    always @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            still_cnt <= 6'h00;
            ref_q <= 1'b0;
            booted <= 1'b0;
            stalled <= 1'b0;
        end
        else
        begin
            ref_q <= ref_clk;
            if (ref_q != ref_clk)
                still_cnt <= 6'h00;
            else if (still_cnt != 6'h3F)
                still_cnt <= still_cnt + 6'h01;
            stalled <= stalled | (still_cnt == 6'h3F);
            booted <= booted | boot_done;
        end
    end
    // ************************************************************
    // Properties
    // ************************************************************
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held past one cycle");
    a_ack_after_req: assert property
        (wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_force_sync_pin: assert property
        (wr_ctrl && wb_dat_i[`SFSM_C_FSYNC] |-> ##[1:3] sync_pin_oe)
        else $error("forced sync not driven");
    a_force_irq_pin: assert property
        (wr_ctrl && wb_dat_i[`SFSM_C_FIRQ] |-> ##[1:3] fault_irq_n_oe)
        else $error("forced interrupt not driven");
    a_fast_uv_gated: assert property ((fast_uv_en & ~fast_ov_en) == 0)
        else $error("fast under-voltage on unmonitored channel");
    a_slow_uv_gated: assert property ((slow_uv_en & ~slow_ov_en) == 0)
        else $error("slow under-voltage on unmonitored channel");
    a_low_power_slow: assert property
        ((!adc_run)[*3] ##1 !adc_run |-> $past(slow_ov_en) == 0)
        else $error("slow compare active with converter stopped");
    a_boot_quiet: assert property
        (!booted |-> fast_ov_en == 0 && !adc_run)
        else $error("monitoring before start-up ended");
    a_clock_latch: assert property (stalled |-> fault_irq_n_oe)
        else $error("lost reference clock not signalled");
    c_bus_write: cover property (wb_ack_o && wb_we_i);
    c_sync_force: cover property (sync_pin_oe);
    c_ref_stall: cover property (stalled);
endmodule
bind sfsm_monitor sfsm_mon_chk #(.NCH(NCH)) chk_u (.sys_clk, .rst_b,
    .clk_en, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
    .wb_sel_i, .wb_ack_o, .ref_clk, .boot_done, .fault_irq_n_oe,
    .sync_pin_oe, .fast_ov_en, .slow_ov_en, .fast_uv_en, .slow_uv_en,
    .adc_run);

// file: sfsm_monitor_bench.sv
`timescale 1ns/1ps
`include "sfsm_consts.vh"
module sfsm_monitor_bench;
    reg sys_clk = 1'b0;
    reg rst_b = 1'b0;
    reg cyc = 1'b0, we = 1'b0;
    reg [7:0] adr = 8'h00, hd = 8'h00;
    reg [31:0] wd = 32'h0, rd = 32'h0;
    reg shdn = 1'b0, slp = 1'b1, hot = 1'b0, boot = 1'b0, serr = 1'b0;
    reg derr = 1'b0, done = 1'b0, lfail = 1'b0, hwv = 1'b0, adcv = 1'b0;
    reg irq_sh = 1'b0, syn_sh = 1'b0, ref_run = 1'b1;
    reg [3:0] ha = 4'h0;
    reg [2:0] ac = 3'h0;
    reg [9:0] ad = 10'h000;
    wire [31:0] rdat;
    wire ack, ref_clk, irq_oe, irq_o, syn_oe, syn_o, irq_pin, syn_pin;
    wire [5:0] fov, sov, fuv, suv;
    wire [23:0] ens = {fov, sov, fuv, suv};
    integer miscompares = 0, n_tests = 0;
    always #2 sys_clk = !sys_clk;
    sfsm_monitor dut_u (.sys_clk, .rst_b, .clk_en(1'b1), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wd),
        .wb_sel_i(4'hF), .wb_dat_o(rdat), .wb_ack_o(ack),
        .shutdown_control_pin(shdn), .sleep_control_pin(slp), .ref_clk,
        .temp_hot(hot), .fault_irq_n_in(irq_pin), .fault_irq_n_out(irq_o),
        .fault_irq_n_oe(irq_oe), .sync_pin_in(syn_pin),
        .sync_pin_out(syn_o), .sync_pin_oe(syn_oe), .boot_done(boot),
        .nvm_single_err(serr), .nvm_double_err(derr), .selftest_done(done),
        .logic_selftest_fail(lfail), .analog_selftest_fail(1'b0),
        .host_wr_valid(hwv), .host_wr_addr(ha), .host_wr_data(hd),
        .host_wr_code_present(1'b0), .host_wr_code(8'h00),
        .adc_valid(adcv), .adc_chan(ac), .adc_data(ad), .fast_ov_en(fov),
        .slow_ov_en(sov), .fast_uv_en(fuv), .slow_uv_en(suv), .adc_run());
    sfsm_host_model host_u (.irq_oe, .irq_out(irq_o), .sync_oe(syn_oe),
        .sync_out(syn_o), .irq_short(irq_sh), .sync_short(syn_sh),
        .irq_pin, .sync_pin(syn_pin), .ref_run, .ref_clk);
    // ************************************************************
    // Shared tasks
    // ************************************************************
    task check(input [31:0] got, input [31:0] exp);
    begin
        n_tests = n_tests + 1;
        if (got !== exp)
        begin
            miscompares = miscompares + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask
    task print_verdict;
    begin
        $display("Comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask
    task wclk(input integer n);
        repeat (n) @(posedge sys_clk);
    endtask
    // Request held until ack is sampled high, then dropped
    task bus(input w, input [7:0] a, input [31:0] d);
        integer i;
    begin
        @(posedge sys_clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        i = 0;
        @(posedge sys_clk);
        while (ack !== 1'b1 && i < 20)
        begin
            i = i + 1;
            @(posedge sys_clk);
        end
        if (i == 20)
        begin
            miscompares = miscompares + 1;
            print_verdict;
        end
        else
        begin
            rd = rdat;
            cyc <= 1'b0;
        end
    end
    endtask
    task rdchk(input [7:0] a, input [31:0] m, input [31:0] e);
    begin
        bus(1'b0, a, 32'h0);
        check(rd & m, e);
    end
    endtask
    task st(input [4:0] e);
        rdchk(`SFSM_A_STATE, 32'h1F, {27'h0, e});
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    task t_boot;
    begin
        @(posedge sys_clk) shdn <= 1'b1;
        wclk(6);
        @(posedge sys_clk) boot <= 1'b1;
        @(posedge sys_clk) boot <= 1'b0;
        st(5'h02);
        rdchk(`SFSM_A_CTRL, 32'h1FF, 32'h0B0);
        rdchk(8'h80, 32'hFFFFFFFF, 32'h0);
        bus(1'b1, `SFSM_A_CHEN, 32'h3F);
        wclk(3);
        check(ens, 24'hFFF000);
    end
    endtask
    task t_active;
    begin
        @(posedge sys_clk) shdn <= 1'b0;
        wclk(6);
        @(posedge sys_clk) shdn <= 1'b1;
        wclk(6);
        st(5'h04);
        bus(1'b1, `SFSM_A_SUVIEN, 32'h05);
        bus(1'b1, `SFSM_A_FUVIEN, 32'h03);
        wclk(3);
        check(ens, 24'hFFF0C5);
        @(posedge sys_clk) adcv <= 1'b1;
        ac <= 3'h2;
        ad <= 10'h2A5;
        @(posedge sys_clk) adcv <= 1'b0;
        rdchk(`SFSM_A_LEVEL + 8'h08, 32'h3FF, 32'h2A5);
        bus(1'b1, `SFSM_A_AMASK, 32'h01);
        @(posedge sys_clk) slp <= 1'b0;
        wclk(6);
        st(5'h08);
        check(ens, 24'hFFF084);
        @(posedge sys_clk) shdn <= 1'b0;
        wclk(6);
        st(5'h02);
        check(ens, 24'hFFF000);
        @(posedge sys_clk) slp <= 1'b1;
        bus(1'b1, `SFSM_A_CTRL, 32'h1B0);
        wclk(2);
        st(5'h04);
        @(posedge sys_clk) shdn <= 1'b1;
        wclk(6);
        @(posedge sys_clk) shdn <= 1'b0;
        wclk(6);
        st(5'h02);
    end
    endtask
    task t_lowpow;
    begin
        bus(1'b1, `SFSM_A_CTRL, 32'h030);
        bus(1'b1, `SFSM_A_CTRL, 32'h130);
        wclk(3);
        st(5'h02);
        check(ens, 24'hFC0000);
        bus(1'b1, `SFSM_A_CTRL, 32'h0B0);
    end
    endtask
    task t_single;
    begin
        bus(1'b1, `SFSM_A_CTRL, 32'h090);
        @(posedge sys_clk) serr <= 1'b1;
        @(posedge sys_clk) serr <= 1'b0;
        rdchk(`SFSM_A_FAULT, 32'h2, 32'h0);
        rdchk(`SFSM_A_TINFO, 32'h1, 32'h1);
        check(irq_pin, 1'b1);
        bus(1'b1, `SFSM_A_CTRL, 32'h0B0);
        @(posedge sys_clk) serr <= 1'b1;
        @(posedge sys_clk) serr <= 1'b0;
        rdchk(`SFSM_A_FAULT, 32'h2, 32'h2);
        check(irq_pin, 1'b0);
        bus(1'b1, `SFSM_A_FAULT, 32'h2);
        wclk(3);
        check(irq_pin, 1'b1);
    end
    endtask
    task t_therm;
    begin
        @(posedge sys_clk) hot <= 1'b1;
        wclk(6);
        bus(1'b1, `SFSM_A_FAULT, 32'h1);
        rdchk(`SFSM_A_FAULT, 32'h1, 32'h1);
        check(irq_pin, 1'b0);
        @(posedge sys_clk) hot <= 1'b0;
        wclk(6);
        bus(1'b1, `SFSM_A_FAULT, 32'h1);
        rdchk(`SFSM_A_FAULT, 32'h1, 32'h0);
        check(irq_pin, 1'b1);
    end
    endtask
    task t_pins;
    begin
        bus(1'b1, `SFSM_A_CTRL, 32'h0B3);
        @(posedge sys_clk) hwv <= 1'b1;
        ha <= 4'h3;
        hd <= 8'h5A;
        @(posedge sys_clk) hwv <= 1'b0;
        rdchk(`SFSM_A_FAULT, 32'h80, 32'h80);
        bus(1'b1, `SFSM_A_CTRL, 32'h0B4);
        bus(1'b1, `SFSM_A_FAULT, 32'h80);
        wclk(8);
        check(irq_pin, 1'b0);
        rdchk(`SFSM_A_FAULT, 32'h100, 32'h0);
        irq_sh <= 1'b1;
        syn_sh <= 1'b1;
        bus(1'b1, `SFSM_A_CTRL, 32'h0BC);
        wclk(8);
        rdchk(`SFSM_A_FAULT, 32'h300, 32'h300);
        bus(1'b1, `SFSM_A_CTRL, 32'h0B0);
        irq_sh <= 1'b0;
        syn_sh <= 1'b0;
    end
    endtask
    task t_test;
    begin
        bus(1'b1, `SFSM_A_CTRL, 32'h0F0);
        @(posedge sys_clk) done <= 1'b1;
        @(posedge sys_clk) done <= 1'b0;
        rdchk(`SFSM_A_TINT, 32'h3, 32'h2);
        rdchk(`SFSM_A_STATE, 32'h100, 32'h100);
        bus(1'b1, `SFSM_A_TINT, 32'h2);
        rdchk(`SFSM_A_TINT, 32'h3, 32'h0);
        @(posedge sys_clk) done <= 1'b1;
        lfail <= 1'b1;
        @(posedge sys_clk) done <= 1'b0;
        lfail <= 1'b0;
        bus(1'b1, `SFSM_A_TINT, 32'h3);
        rdchk(`SFSM_A_TINT, 32'h3, 32'h1);
        rdchk(`SFSM_A_TINFO, 32'h4, 32'h4);
        check(irq_pin, 1'b0);
    end
    endtask
    task t_fail;
    begin
        @(posedge sys_clk) rst_b <= 1'b0;
        wclk(8);
        @(posedge sys_clk) rst_b <= 1'b1;
        @(posedge sys_clk) derr <= 1'b1;
        @(posedge sys_clk) derr <= 1'b0;
        @(posedge sys_clk) boot <= 1'b1;
        @(posedge sys_clk) boot <= 1'b0;
        st(5'h10);
        bus(1'b1, `SFSM_A_FAULT, 32'h4);
        rdchk(`SFSM_A_FAULT, 32'h4, 32'h4);
        rdchk(`SFSM_A_TINFO, 32'h2, 32'h2);
        check(irq_pin, 1'b0);
        @(posedge sys_clk) ref_run <= 1'b0;
        wclk(80);
        bus(1'b1, `SFSM_A_FAULT, 32'h8);
        rdchk(`SFSM_A_FAULT, 32'h8, 32'h8);
    end
    endtask
    initial
    begin
        wclk(8);
        rst_b <= 1'b1;
        t_boot;
        t_active;
        t_lowpow;
        t_single;
        t_therm;
        t_pins;
        t_test;
        t_fail;
        print_verdict;
    end
endmodule
